//--- hw/display_host.sv
// Host controller that sends command packets to the display module and waits for answers.
// Assumes an external byte serialiser with valid/ready and a receiver that gives byte pulses.
//
// Overview of operation
// - Save boot state: send code 0x04, no payload; expect 0x44 answer.
// - Reporting and watchdog settings are never saved; host must re-enable them.
// - Self reboot: code 0x05 with payload 8, 18, 99.
// - Self reboot acknowledge may take 3 seconds; timeout allows for it.
// - Host reset: code 0x05 with payload 12, 28, 97; ack comes at once.
// - Host power cycle: code 0x05 with payload 3, 11, 95.
// - Line one text: code 0x07 with exactly 16 bytes; answer 0x47.
// - Line two text: code 0x08 with exactly 16 bytes; answer 0x48.
// - Glyph: code 0x09, index 0-7 then eight rows 0 to 63; answer 0x49.
// - Cursor position: code 0x0B, column 0-15 then row 0-1; answer 0x4B.
// - Power control pins must stay in default drive mode on the device.
// - Type byte: two-bit class above six-bit code; answers echo the code.
// - Each packet ends with a 16-bit check word, low byte first.
`include "display_host_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module display_host #(
    parameter int unsigned RSP_TIMEOUT_CYC = `RSP_TIMEOUT_MS * `CYC_PER_MS,
    parameter int unsigned REBOOT_ACK_CYC  = `REBOOT_ACK_MS * `CYC_PER_MS,
    parameter int unsigned QUIET_CYC       = (`HOST_RESET_MS + `REBOOT_QUIET_MS) * `CYC_PER_MS
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic                    req_valid,
    input  wire display_host_pkg::cmd_req_t req,
    output logic                         req_ready,
    output logic                         done,
    output display_host_pkg::cmd_result_t result,
    output logic                         tx_valid,
    output logic [7:0]                   tx_data,
    input  wire logic                    tx_ready,
    input  wire logic                    rx_valid,
    input  wire logic [7:0]              rx_data
);

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_step

    typedef enum logic [1:0] {
        s_idle  = 2'b00,
        s_send  = 2'b01,
        s_wait  = 2'b11,
        s_quiet = 2'b10
    } state_t;

    state_t                     state;
    display_host_pkg::cmd_kind_t kind;
    logic [17:0][7:0]           tx_buf;
    logic [4:0]                 tx_len;
    logic [4:0]                 tx_idx;
    logic [15:0]                tx_crc;
    logic [31:0]                timer;

    ////////////////////////////////////////////////////////////////////////////////
    // Packet building.
    logic [5:0]       b_code;
    logic [4:0]       b_len;
    logic [15:0][7:0] b_data;

    always_comb begin
        b_code = `CODE_SAVE_BOOT;
        b_len  = `LEN_NONE;
        b_data = '0;
        case (req.kind)
            display_host_pkg::cmd_save_boot: begin
                b_code = `CODE_SAVE_BOOT;
            end
            display_host_pkg::cmd_reboot_self: begin
                b_code = `CODE_REBOOT;
                b_len  = `LEN_REBOOT;
                b_data[0] = `MAGIC_SELF_0;
                b_data[1] = `MAGIC_SELF_1;
                b_data[2] = `MAGIC_SELF_2;
            end
            display_host_pkg::cmd_reset_host: begin
                b_code = `CODE_REBOOT;
                b_len  = `LEN_REBOOT;
                b_data[0] = `MAGIC_RESET_0;
                b_data[1] = `MAGIC_RESET_1;
                b_data[2] = `MAGIC_RESET_2;
            end
            display_host_pkg::cmd_power_cycle_host: begin
                b_code = `CODE_REBOOT;
                b_len  = `LEN_REBOOT;
                b_data[0] = `MAGIC_POWER_0;
                b_data[1] = `MAGIC_POWER_1;
                b_data[2] = `MAGIC_POWER_2;
            end
            display_host_pkg::cmd_clear: begin
                b_code = `CODE_CLEAR;
            end
            display_host_pkg::cmd_line1: begin
                b_code = `CODE_LINE1;
                b_len  = `LEN_LINE;
                b_data = req.text;
            end
            display_host_pkg::cmd_line2: begin
                b_code = `CODE_LINE2;
                b_len  = `LEN_LINE;
                b_data = req.text;
            end
            display_host_pkg::cmd_glyph: begin
                b_code = `CODE_GLYPH;
                b_len  = `LEN_GLYPH;
                b_data[0] = req.arg0 & `GLYPH_IDX_MASK;
                for (int r = 0; r < 8; r++) begin
                    b_data[r + 1] = req.text[r] & `GLYPH_ROW_MASK;
                end
            end
            display_host_pkg::cmd_mem_read: begin
                b_code = `CODE_MEM_READ;
                b_len  = `LEN_ONE;
                b_data[0] = req.arg0;
            end
            display_host_pkg::cmd_cursor_pos: begin
                b_code = `CODE_CURSOR_POS;
                b_len  = `LEN_TWO;
                b_data[0] = req.arg0 & `COL_MASK;
                b_data[1] = req.arg1 & `ROW_MASK;
            end
            display_host_pkg::cmd_cursor_style: begin
                b_code = `CODE_CURSOR_STYLE;
                b_len  = `LEN_ONE;
                b_data[0] = req.arg0;
            end
            display_host_pkg::cmd_contrast: begin
                b_code = `CODE_CONTRAST;
                b_len  = `LEN_ONE;
                b_data[0] = req.arg0;
            end
            default: begin
                b_code = `CODE_SAVE_BOOT;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit path.
    wire        accept    = (state == s_idle) && req_valid && req_ready;
    wire        tx_fire   = tx_valid && tx_ready;
    wire [4:0]  tx_body   = tx_len + `LEN_HDR;
    wire [4:0]  next_idx  = tx_idx + 5'h01;
    wire [15:0] crc_after = crc_step(tx_crc, tx_data);
    wire        in_body   = tx_idx < tx_body;
    wire        tx_last   = tx_idx == tx_body + 5'h01;
    wire [7:0]  next_byte = (next_idx < tx_body) ? tx_buf[next_idx] :
                            (next_idx == tx_body) ? ~crc_after[7:0] : ~tx_crc[15:8];
    wire        long_wait = (kind == display_host_pkg::cmd_reboot_self);
    wire        need_quiet = (kind == display_host_pkg::cmd_reset_host) ||
                             (kind == display_host_pkg::cmd_power_cycle_host);

    ////////////////////////////////////////////////////////////////////////////////
    // Receive parser; reports and damaged packets are dropped, only matching answers count.
    logic [4:0]      rx_pos;
    logic [7:0]      rx_type;
    logic [4:0]      rx_len;
    logic [15:0]     rx_crc;
    logic [7:0]      rx_lo;
    logic [8:0][7:0] rx_buf;
    logic            rx_ok;

    wire [4:0] rx_body   = rx_len + `LEN_HDR;
    wire       rx_len_bad = (rx_pos == 5'h01) && (rx_data[4:0] > `LEN_MAX || rx_data[7:5] != 3'h0);
    wire       rx_hi     = (rx_pos == rx_body + 5'h01) && (rx_pos > 5'h01);
    wire       rx_good   = rx_valid && rx_hi && ({rx_data, rx_lo} == ~rx_crc);
    wire [4:0] rx_didx   = rx_pos - `LEN_HDR;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_pos <= '0;
            rx_type <= '0;
            rx_len <= '0;
            rx_crc <= `CRC_INIT;
            rx_lo <= '0;
            rx_buf <= '0;
            rx_ok <= 1'b0;
        end else begin
            rx_ok <= rx_good;
            if (rx_valid) begin
                if (rx_pos == 5'h00) begin
                    rx_type <= rx_data;
                    rx_crc <= crc_step(`CRC_INIT, rx_data);
                    rx_pos <= 5'h01;
                end else if (rx_len_bad || rx_hi) begin
                    rx_pos <= '0;
                end else begin
                    if (rx_pos == 5'h01) begin
                        rx_len <= rx_data[4:0];
                    end
                    if (rx_pos < rx_body || rx_pos == 5'h01) begin
                        rx_crc <= crc_step(rx_crc, rx_data);
                    end else begin
                        rx_lo <= rx_data;
                    end
                    if (rx_pos > 5'h01 && rx_didx < 5'h09) begin
                        rx_buf[rx_didx[3:0]] <= rx_data;
                    end
                    rx_pos <= rx_pos + 5'h01;
                end
            end
        end
    end

    wire rsp_match = rx_ok && (rx_type[5:0] == tx_buf[0][5:0]);
    wire rsp_ack   = rsp_match && (rx_type[7:6] == `CLASS_RESPONSE);
    wire rsp_err   = rsp_match && (rx_type[7:6] == `CLASS_ERROR);
    wire is_mem    = (kind == display_host_pkg::cmd_mem_read) && (rx_len == `LEN_MEM_RSP);

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= s_idle;
            kind <= display_host_pkg::cmd_save_boot;
            tx_buf <= '0;
            tx_len <= '0;
            tx_idx <= '0;
            tx_crc <= `CRC_INIT;
            tx_valid <= 1'b0;
            tx_data <= '0;
            timer <= '0;
            req_ready <= 1'b0;
            done <= 1'b0;
            result <= '0;
        end else begin
            done <= 1'b0;
            case (state)
                s_idle: begin
                    req_ready <= 1'b1;
                    if (accept) begin
                        req_ready <= 1'b0;
                        kind <= req.kind;
                        tx_buf <= {b_data, 3'h0, b_len, `CLASS_COMMAND, b_code};
                        tx_len <= b_len;
                        tx_idx <= '0;
                        tx_crc <= `CRC_INIT;
                        tx_data <= {`CLASS_COMMAND, b_code};
                        tx_valid <= 1'b1;
                        state <= s_send;
                    end
                end
                s_send: begin
                    if (tx_fire) begin
                        if (in_body) begin
                            tx_crc <= crc_after;
                        end
                        if (tx_last) begin
                            tx_valid <= 1'b0;
                            // Self reboot acks only after boot.
                            timer <= long_wait ? REBOOT_ACK_CYC : RSP_TIMEOUT_CYC;
                            state <= s_wait;
                        end else begin
                            tx_idx <= next_idx;
                            tx_data <= next_byte;
                        end
                    end
                end
                s_wait: begin
                    timer <= timer - 32'h1;
                    if (rsp_ack || rsp_err) begin
                        done <= 1'b1;
                        result.status <= rsp_ack ? display_host_pkg::st_ok : display_host_pkg::st_error;
                        result.addr <= is_mem ? rx_buf[0] : 8'h00;
                        result.mem <= is_mem ? rx_buf[8:1] : '0;
                        // Commands sent during reboot would be lost.
                        if (rsp_ack && need_quiet) begin
                            timer <= QUIET_CYC;
                            state <= s_quiet;
                        end else begin
                            state <= s_idle;
                        end
                    end else if (timer == 32'h0) begin
                        done <= 1'b1;
                        result <= '0;
                        result.status <= display_host_pkg::st_timeout;
                        state <= s_idle;
                    end
                end
                s_quiet: begin
                    timer <= timer - 32'h1;
                    if (timer == 32'h0) begin
                        state <= s_idle;
                    end
                end
                default: begin
                    state <= s_idle;
                end
            endcase
        end
    end

endmodule : display_host

`default_nettype wire

//--- shared/display_host_defs.svh
// Named constants for the display module command host.
// Assumes a packet link carrying type, length, payload and a 16-bit check word.
`ifndef DISPLAY_HOST_DEFS_SVH
`define DISPLAY_HOST_DEFS_SVH

`define CLK_HZ             100000000
`define CYC_PER_MS         (`CLK_HZ / 1000)
`define RSP_TIMEOUT_MS     250
`define REBOOT_ACK_MS      3000
`define HOST_RESET_MS      1500
`define REBOOT_QUIET_MS    3000

`define CODE_SAVE_BOOT     6'h04
`define CODE_REBOOT        6'h05
`define CODE_CLEAR         6'h06
`define CODE_LINE1         6'h07
`define CODE_LINE2         6'h08
`define CODE_GLYPH         6'h09
`define CODE_MEM_READ      6'h0A
`define CODE_CURSOR_POS    6'h0B
`define CODE_CURSOR_STYLE  6'h0C
`define CODE_CONTRAST      6'h0D

`define CLASS_COMMAND      2'h0
`define CLASS_RESPONSE     2'h1
`define CLASS_REPORT       2'h2
`define CLASS_ERROR        2'h3

`define MAGIC_SELF_0       8'h08
`define MAGIC_SELF_1       8'h12
`define MAGIC_SELF_2       8'h63
`define MAGIC_RESET_0      8'h0C
`define MAGIC_RESET_1      8'h1C
`define MAGIC_RESET_2      8'h61
`define MAGIC_POWER_0      8'h03
`define MAGIC_POWER_1      8'h0B
`define MAGIC_POWER_2      8'h5F

`define LEN_NONE           5'h00
`define LEN_ONE            5'h01
`define LEN_TWO            5'h02
`define LEN_REBOOT         5'h03
`define LEN_GLYPH          5'h09
`define LEN_LINE           5'h10
`define LEN_MAX            5'h12
`define LEN_MEM_RSP        5'h09
`define LEN_HDR            5'h02

`define GLYPH_IDX_MASK     8'h07
`define GLYPH_ROW_MASK     8'h3F
`define COL_MASK           8'h0F
`define ROW_MASK           8'h01

`define CRC_INIT           16'hFFFF
`define CRC_POLY           16'h8408

`endif

//--- shared/display_host_pkg.sv
// Types shared by the display module command host and its users.
// Assumes the constants header is compiled alongside.
package display_host_pkg;

    typedef enum logic [3:0] {
        cmd_save_boot, cmd_reboot_self, cmd_reset_host, cmd_power_cycle_host,
        cmd_clear, cmd_line1, cmd_line2, cmd_glyph, cmd_mem_read,
        cmd_cursor_pos, cmd_cursor_style, cmd_contrast
    } cmd_kind_t;

    typedef enum logic [1:0] {
        st_ok, st_error, st_timeout
    } status_t;

    typedef struct packed {
        cmd_kind_t        kind;
        logic [7:0]       arg0;
        logic [7:0]       arg1;
        logic [15:0][7:0] text;
    } cmd_req_t;

    typedef struct packed {
        status_t         status;
        logic [7:0]      addr;
        logic [7:0][7:0] mem;
    } cmd_result_t;

endpackage : display_host_pkg

//--- testbench/device_model.sv
// Behavioural display module on the far side of the packet link.
// Assumes the host hands one byte per handshake; answers arrive as byte pulses.
`timescale 1ns/1ns
`default_nettype none
module device_model #(
    parameter int SLOW_CYC = 300
) (
    input  wire logic       core_clk,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output var logic        tx_ready,
    output var logic        rx_valid,
    output var logic [7:0]  rx_data,
    input  wire logic [1:0] mode
);
    logic [7:0] pkt[$];
    logic [7:0] last[$];
    logic [7:0] mem[256];
    logic [7:0] col;
    logic [7:0] row;
    logic       crc_ok;
    function automatic logic [15:0] crc(logic [7:0] q[$], int n);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 0; i < n; i++) begin
            c ^= {8'h00, q[i]};
            for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
        end
        return ~c;
    endfunction : crc
    task automatic send(logic [7:0] q[$]);
        logic [15:0] c;
        c = crc(q, q.size());
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) begin
            rx_valid <= 1'b1;
            rx_data  <= q[i];
            @(posedge core_clk);
            rx_valid <= 1'b0;
            rx_data  <= ~q[i];
            @(posedge core_clk);
        end
    endtask : send
    ////////////////////////////////////////////////////////////////////////
    task automatic answer();
        logic [7:0] a[$];
        logic [7:0] k;
        int         n;
        logic       bad;
        k = last[0];
        n = last[1];
        a = '{8'h40 | k, 8'h00};
        bad = 1'b0;
        case (k)
            8'h04: bad = n != 0 || mode == 2'h1;
            8'h05: bad = n != 3 || !({last[2], last[3], last[4]} inside
                {24'h081263, 24'h0C1C61, 24'h030B5F});
            8'h06: begin
                for (int i = 0; i < 16; i++) mem[8'h80 + i] = 8'h20;
                for (int i = 0; i < 16; i++) mem[8'hC0 + i] = 8'h20;
                col = 8'h00;
                row = 8'h00;
            end
            8'h07, 8'h08: begin
                bad = n != 16;
                for (int i = 0; i < 16; i++) mem[(k == 8'h07 ? 8'h80 : 8'hC0) + i] = last[2 + i];
            end
            8'h09: begin
                bad = n != 9 || last[2] > 8'h07;
                for (int r = 0; r < 8; r++) mem[8'h40 + last[2] * 8 + r] = last[3 + r];
            end
            8'h0A: begin
                a = '{8'h4A, 8'h09, last[2]};
                for (int i = 0; i < 8; i++) a.push_back(mem[8'(last[2] + i)]);
            end
            8'h0B: begin
                col = last[2];
                row = last[3];
                bad = n != 2 || col > 8'h0F || row > 8'h01;
            end
            8'h0C, 8'h0D: bad = n != 1;
            default: bad = 1'b1;
        endcase
        if (bad || mode == 2'h1) a = '{8'hC0 | k, 8'h00};
        // Self reboot ack comes late, while the module boots.
        repeat (k == 8'h05 && last[2] == 8'h08 ? SLOW_CYC : 2) @(posedge core_clk);
        if (mode == 2'h3) send('{8'h80, 8'h01, 8'h05});
        if (mode != 2'h2) send(a);
        // After a host reset or power cycle the module reboots and hears nothing.
        if (k == 8'h05 && last[2] != 8'h08) repeat (200) @(posedge core_clk);
    endtask : answer
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        crc_ok   = 1'b0;
        forever begin
            @(posedge core_clk);
            if (tx_valid && tx_ready) pkt.push_back(tx_data);
            tx_ready <= ~tx_ready;
            if (pkt.size() > 1 && pkt.size() == pkt[1] + 4) begin
                last = pkt;
                pkt.delete();
                crc_ok = crc(last, last.size() - 2) == {last[last.size() - 1], last[last.size() - 2]};
                if (crc_ok) answer();
            end
        end
    end
endmodule : device_model
`default_nettype wire

//--- testbench/display_host_checker.sv
// Port checker for the display command host.
// Assumes it is bound to every display_host instance and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module display_host_checker (
    input wire logic                          core_clk,
    input wire logic                          rst,
    input wire logic                          req_valid,
    input wire display_host_pkg::cmd_req_t    req,
    input wire logic                          req_ready,
    input wire logic                          done,
    input wire display_host_pkg::cmd_result_t result,
    input wire logic                          tx_valid,
    input wire logic [7:0]                    tx_data,
    input wire logic                          tx_ready,
    input wire logic                          rx_valid,
    input wire logic [7:0]                    rx_data
);
    // Tables follow the declaration order of the command kinds.
    localparam logic [7:0] CODE [12] = '{8'h04, 8'h05, 8'h05, 8'h05, 8'h06, 8'h07,
                                         8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
    localparam logic [7:0] LEN [12] = '{8'h00, 8'h03, 8'h03, 8'h03, 8'h00, 8'h10,
                                        8'h10, 8'h09, 8'h01, 8'h02, 8'h01, 8'h01};
    localparam logic [7:0] MAG [12] = '{1:8'h08, 2:8'h0C, 3:8'h03, default: 8'h00};
    display_host_pkg::cmd_kind_t kind;
    logic [4:0]                  cnt;
    wire logic acc  = req_valid && req_ready;
    wire logic take = tx_valid && tx_ready;
    wire logic quiet = done && result.status == display_host_pkg::st_ok
        && (kind == display_host_pkg::cmd_reset_host
        || kind == display_host_pkg::cmd_power_cycle_host);
    always_ff @(posedge core_clk) begin
        if (acc) kind <= req.kind;
        cnt <= acc ? 5'h00 : cnt + {4'h0, take};
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_type; acc |=> tx_valid && tx_data == CODE[kind]; endproperty
    a_type: assert property (p_type) else $error("wrong type byte");
    property p_len; take && cnt == 5'h01 |-> tx_data == LEN[kind]; endproperty
    a_len: assert property (p_len) else $error("wrong length byte");
    property p_magic; take && cnt == 5'h02 && MAG[kind] != 8'h00 |-> tx_data == MAG[kind];
    endproperty
    a_magic: assert property (p_magic) else $error("wrong magic byte");
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
    a_hold: assert property (p_hold) else $error("byte not held");
    property p_busy; acc |=> !req_ready [*2]; endproperty
    a_busy: assert property (p_busy) else $error("second command taken");
    property p_pulse; done |=> !done; endproperty
    a_pulse: assert property (p_pulse) else $error("done longer than a cycle");
    property p_quiet; quiet |=> !req_ready [*8]; endproperty
    a_quiet: assert property (p_quiet) else $error("no quiet time");
    property p_err; done && result.status == display_host_pkg::st_error |-> ##[1:2] req_ready;
    endproperty
    a_err: assert property (p_err) else $error("idle late after error");
    property p_addr; done && kind != display_host_pkg::cmd_mem_read |-> result.addr == 8'h00;
    endproperty
    a_addr: assert property (p_addr) else $error("stray address echo");
    c_tmo: cover property (done && result.status == display_host_pkg::st_timeout);
    c_err: cover property (done && result.status == display_host_pkg::st_error);
    c_quiet: cover property (quiet);
endmodule : display_host_checker
bind display_host display_host_checker display_host_checker_i (
    .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .done(done), .result(result), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the display command host with a device model.
// Assumes the checker binds itself to the host.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [7:0] CODE [12] = '{8'h04, 8'h05, 8'h05, 8'h05, 8'h06, 8'h07,
                                         8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
    localparam logic [7:0] LEN [12] = '{0, 3, 3, 3, 0, 16, 16, 9, 1, 2, 1, 1};
    localparam logic [23:0] MAG [3] = '{24'h081263, 24'h0C1C61, 24'h030B5F};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic [1:0] mode = 2'h0;
    display_host_pkg::cmd_req_t req = '0;
    display_host_pkg::cmd_result_t result;
    logic req_ready, done, tx_valid, tx_ready, rx_valid;
    logic [7:0] tx_data, rx_data;
    int fails = 0;
    int n_tests = 0;
    always #5 core_clk = ~core_clk;
    display_host #(.RSP_TIMEOUT_CYC(200), .REBOOT_ACK_CYC(400), .QUIET_CYC(300)) display_host_i (
        .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .done(done), .result(result), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));
    device_model #(.SLOW_CYC(300)) device_model_i (.core_clk(core_clk), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .mode(mode));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    task automatic run(display_host_pkg::cmd_kind_t k, logic [7:0] a0, logic [7:0] a1,
                       display_host_pkg::status_t st);
        int i;
        req.kind <= k;
        req.arg0 <= a0;
        req.arg1 <= a1;
        req_valid <= 1'b1;
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (!req_ready && i < 2000);
        req_valid <= 1'b0;
        do begin
            @(posedge core_clk);
            i++;
        end while (!done && i < 4000);
        check("done wait", i >= 4000, 1'b0);
        if (i >= 4000) test_done();
        check("status", result.status, st);
        check("type", device_model_i.last[0], CODE[k]);
        check("length", device_model_i.last[1], LEN[k]);
        check("check word", device_model_i.crc_ok, 1'b1);
    endtask : run
    task automatic t_text();
        for (int i = 0; i < 16; i++) req.text[i] <= 8'h41 + 8'(i);
        run(display_host_pkg::cmd_clear, 8'h00, 8'h00, display_host_pkg::st_ok);
        check("cursor home", {device_model_i.col, device_model_i.row}, 16'h0000);
        run(display_host_pkg::cmd_mem_read, 8'hC0, 8'h00, display_host_pkg::st_ok);
        check("blank", result.mem, {8{8'h20}});
        check("addr echo", result.addr, 8'hC0);
        run(display_host_pkg::cmd_line2, 8'h00, 8'h00, display_host_pkg::st_ok);
        run(display_host_pkg::cmd_mem_read, 8'hC0, 8'h00, display_host_pkg::st_ok);
        check("line two", result.mem, req.text[7:0]);
        run(display_host_pkg::cmd_line1, 8'h00, 8'h00, display_host_pkg::st_ok);
        run(display_host_pkg::cmd_mem_read, 8'h88, 8'h00, display_host_pkg::st_ok);
        check("line one", result.mem, req.text[15:8]);
    endtask : t_text
    task automatic t_glyph_cursor();
        // Index 11 and rows above 63 must be trimmed by the host to legal values.
        run(display_host_pkg::cmd_glyph, 8'h0B, 8'h00, display_host_pkg::st_ok);
        check("glyph index", device_model_i.last[2], 8'h03);
        run(display_host_pkg::cmd_mem_read, 8'h58, 8'h00, display_host_pkg::st_ok);
        check("glyph rows", result.mem, 64'h0807060504030201);
        run(display_host_pkg::cmd_cursor_pos, 8'h1F, 8'h03, display_host_pkg::st_ok);
        check("cursor", {device_model_i.col, device_model_i.row}, 16'h0F01);
        run(display_host_pkg::cmd_cursor_style, 8'h02, 8'h00, display_host_pkg::st_ok);
        run(display_host_pkg::cmd_contrast, 8'h5A, 8'h00, display_host_pkg::st_ok);
        check("contrast", device_model_i.last[2], 8'h5A);
    endtask : t_glyph_cursor
    task automatic t_save_reboot();
        run(display_host_pkg::cmd_save_boot, 8'h00, 8'h00, display_host_pkg::st_ok);
        mode <= 2'h1;
        run(display_host_pkg::cmd_save_boot, 8'h00, 8'h00, display_host_pkg::st_error);
        run(display_host_pkg::cmd_line1, 8'h00, 8'h00, display_host_pkg::st_error);
        mode <= 2'h0;
        for (int j = 1; j < 4; j++) begin
            run(display_host_pkg::cmd_kind_t'(j), 8'h00, 8'h00, display_host_pkg::st_ok);
            check("magic", {device_model_i.last[2], device_model_i.last[3],
                device_model_i.last[4]}, MAG[j - 1]);
            repeat (250) @(posedge core_clk);
            check("quiet", req_ready, j == 1);
        end
    endtask : t_save_reboot
    task automatic t_link();
        mode <= 2'h2;
        run(display_host_pkg::cmd_contrast, 8'h01, 8'h00, display_host_pkg::st_timeout);
        mode <= 2'h3;
        run(display_host_pkg::cmd_clear, 8'h00, 8'h00, display_host_pkg::st_ok);
        mode <= 2'h0;
    endtask : t_link
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_text();
        t_glyph_cursor();
        t_save_reboot();
        t_link();
        test_done();
    end
endmodule : testbench
`default_nettype wire
